// ### shared/hdm_pkg.sv
// Purpose: constants, field layout and mode types of the half multiply-add path
// Assumes: 32-bit APB register words, byte addresses
// Notes: all config fields reset to zero
package hdm_pkg;
  localparam int unsigned OPW   = 18;
  localparam int unsigned NMUL  = 4;
  localparam int unsigned PRODW = 36;
  localparam int unsigned PW    = 38;
  localparam int unsigned SW    = 39;
  localparam int unsigned ACCW  = 44;
  localparam int unsigned POSW  = 6;

  localparam logic [11:0] ADDR_CTRL  = 12'h000;
  localparam logic [11:0] ADDR_ARITH = 12'h004;
  localparam logic [11:0] ADDR_STAT  = 12'h008;

  localparam int unsigned CTRL_CASC  = 0;
  localparam int unsigned CTRL_LOOP  = 1;
  localparam int unsigned CTRL_WID   = 2;
  localparam int unsigned CTRL_PIPE  = 4;
  localparam int unsigned CTRL_SUB0  = 5;
  localparam int unsigned CTRL_SUB1  = 6;
  localparam int unsigned CTRL_S2    = 7;
  localparam int unsigned CTRL_CHAIN = 9;
  localparam int unsigned CTRL_RSRC  = 10;
  localparam int unsigned CTRL_DLY   = 12;
  localparam int unsigned CTRL_ENAI  = 14;
  localparam int unsigned CTRL_CLRI  = 16;
  localparam int unsigned CTRL_ENAL  = 18;
  localparam int unsigned CTRL_CLRL  = 20;
  localparam int unsigned CTRL_BYP   = 24;
  localparam int unsigned ARITH_RND  = 0;
  localparam int unsigned ARITH_SAT  = 8;

  localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
  localparam logic [31:0] ARITH_RST = 32'h0000_0000;

  typedef enum logic [1:0] {W9, W12, W18, W36} hdm_width_e;
  typedef enum logic [1:0] {S2_PASS, S2_SUM4, S2_ACCUM, S2_MUL36} hdm_stage2_e;
  typedef enum logic [1:0] {RS_MULT, RS_ADD1, RS_PIPE, RS_ADD2} hdm_rsrc_e;
endpackage

// ### shared/hdm_rs_if.sv
// Purpose: carrier between the datapath and one round/saturate unit
// Assumes: purely combinational unit
// Notes: none
`timescale 1ns/1ps
interface hdm_rs_if;
  import hdm_pkg::*;
  logic [ACCW-1:0] din;
  logic [ACCW-1:0] dout;
  logic            doRound;
  logic            doSat;
  logic [POSW-1:0] rndPos;
  logic [POSW-1:0] satMsb;
  logic            ovf;
  modport unit (input din, doRound, doSat, rndPos, satMsb, output dout, ovf);
  modport user (output din, doRound, doSat, rndPos, satMsb, input dout, ovf);
endinterface

// ### design/hdm_round_sat.sv
// Purpose: rounding followed by saturation on a 44-bit signed word
// Assumes: rndPos and satMsb at most 43
// Notes: combinational; the caller registers the result
`timescale 1ns/1ps
module hdm_round_sat
  import hdm_pkg::*;
(
  hdm_rs_if.unit rs
);
  logic signed [ACCW:0] x;
  logic signed [ACCW:0] r;
  logic signed [ACCW:0] hi;
  logic signed [ACCW:0] lo;
  logic signed [ACCW:0] y;
  localparam logic signed [ACCW:0] ONE = 45'sh1;

  always_comb begin
    x = signed'({rs.din[ACCW-1], rs.din});
    r = x;
    // half-lsb add then truncate: round half up
    if (rs.doRound && rs.rndPos != '0) begin
      r = x + (ONE <<< (rs.rndPos - 6'h01));
      r = r & ~((ONE <<< rs.rndPos) - ONE);
    end
    hi = (ONE <<< rs.satMsb) - ONE;
    lo = -(ONE <<< rs.satMsb);
    y = r;
    rs.ovf = 1'b0;
    // saturation sees the rounded value
    if (rs.doSat) begin
      if (r > hi) begin
        y = hi;
        rs.ovf = 1'b1;
      end else if (r < lo) begin
        y = lo;
        rs.ovf = 1'b1;
      end
    end
    rs.dout = y[ACCW-1:0];
  end
endmodule // hdm_round_sat

// ### design/hdm_half_mac.sv
// Purpose: input banks, multipliers, adders, pipeline and round/saturate of one half slice
// Assumes: all inputs synchronous to mclk; APB slave with zero wait states
// Notes: clear lines act at the next edge, not asynchronously
// Contract
// - all registers rising edge, zero after reset
// - each operand registered or bypassed
// - input registers use selected enable/clear line
// - nine 18-bit banks, eight feed multipliers
// - ninth bank delays the cascade input
// - operand A from routing or cascade, static
// - A register feeds next A register below
// - first B operand may take loopback
// - cascade only on A at 18x18
// - loopback only at 18x18, one per half
// - native 9, 12, 18, 36 widths
// - sign controls select signed or unsigned
// - product unsigned only if both unsigned
// - one A and one B sign per half
// - full precision except loopback, which takes 18 bits of result 0
// - two first-stage adders, static add/subtract
// - first-stage result routes to later stages
// - optional pipeline stage adds one cycle
// - two 44-bit second-stage adders, four modes
// - second stage fed by own half, plus chainIn in S2_SUM4
// - two round/sat units, round before saturate
// - round and saturate enabled high, independent
// - halves share only clock, enable, clear
`timescale 1ns/1ps
module hdm_half_mac
  import hdm_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 clkEn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic      [31:0]          prdata,
  output logic                      pslverr,
  input  wire logic [3:0]           ena,
  input  wire logic [3:0]           aclr,
  input  wire logic [NMUL*OPW-1:0]  dataA,
  input  wire logic [NMUL*OPW-1:0]  dataB,
  input  wire logic                 signA,
  input  wire logic                 signB,
  input  wire logic                 roundEn,
  input  wire logic                 saturateEn,
  input  wire logic                 zeroLoopback,
  input  wire logic [OPW-1:0]       scanIn,
  output logic      [OPW-1:0]       scanOut,
  input  wire logic [ACCW-1:0]      chainIn,
  output logic      [ACCW-1:0]      result0,
  output logic      [ACCW-1:0]      result1,
  output logic      [1:0]           satOvf,
  output logic                      accOvf
);
  logic [31:0]          ctrl_q;
  logic [31:0]          arith_q;
  logic [31:0]          prdata_q;
  logic [31:0]          statWord;
  logic                 mapped;
  hdm_width_e           width;
  hdm_stage2_e          s2Mode;
  hdm_rsrc_e            rsSrc;
  logic                 w36;
  logic                 cascAct;
  logic                 lbAct;
  logic                 enaIn;
  logic                 clrIn;
  logic                 enaL;
  logic                 clrL;
  logic [OPW-1:0]       bankA_q [NMUL];
  logic [OPW-1:0]       bankB_q [NMUL];
  logic [OPW-1:0]       aOp     [NMUL];
  logic [OPW-1:0]       bOp     [NMUL];
  logic [OPW-1:0]       dlyBank_q;
  logic signed [PW-1:0] prod    [NMUL];
  logic signed [SW-1:0] s       [2];
  logic signed [SW-1:0] pipeS_q [2];
  logic signed [PW-1:0] pipeP0_q;
  logic signed [PW-1:0] pipeP3_q;
  logic signed [SW-1:0] st2S    [2];
  logic signed [PW-1:0] st2P0;
  logic signed [PW-1:0] st2P3;
  logic [ACCW-1:0]      sum4;
  logic [71:0]          m72;
  logic [ACCW-1:0]      st2     [2];
  logic [ACCW-1:0]      acc_q;
  logic [ACCW:0]        accSum;
  logic                 accOvf_q;
  logic [ACCW-1:0]      result_q [2];
  logic [1:0]           satOvf_q;

  // ---------------- APB register file ----------------
  assign mapped  = paddr == ADDR_CTRL || paddr == ADDR_ARITH || paddr == ADDR_STAT;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata  = prdata_q;
  assign statWord = {27'h0, cascAct, lbAct, accOvf_q, satOvf_q};

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q  <= CTRL_RST;
      arith_q <= ARITH_RST;
    end else if (clkEn && psel && penable && pwrite) begin
      // status is read-only; writes to it are dropped
      if (paddr == ADDR_CTRL) begin
        ctrl_q <= pwdata;
      end
      if (paddr == ADDR_ARITH) begin
        arith_q <= pwdata;
      end
    end
  end

  // read data is latched in the setup cycle so it is a flop output
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0;
    end else if (clkEn && psel && !penable) begin
      case (paddr)
        ADDR_CTRL:  prdata_q <= ctrl_q;
        ADDR_ARITH: prdata_q <= arith_q;
        ADDR_STAT:  prdata_q <= statWord;
        default:    prdata_q <= 32'h0;
      endcase
    end
  end

  // ---------------- static configuration ----------------
  assign width   = hdm_width_e'(ctrl_q[CTRL_WID +: 2]);
  assign s2Mode  = hdm_stage2_e'(ctrl_q[CTRL_S2 +: 2]);
  assign rsSrc   = hdm_rsrc_e'(ctrl_q[CTRL_RSRC +: 2]);
  assign w36     = width == W36;
  assign cascAct = ctrl_q[CTRL_CASC] && width == W18;
  assign lbAct   = ctrl_q[CTRL_LOOP] && width == W18;
  // enable/clear lines are the only things shared with the other half
  assign enaIn = clkEn && ena[ctrl_q[CTRL_ENAI +: 2]];
  assign clrIn = clkEn && aclr[ctrl_q[CTRL_CLRI +: 2]];
  assign enaL  = clkEn && ena[ctrl_q[CTRL_ENAL +: 2]];
  assign clrL  = clkEn && aclr[ctrl_q[CTRL_CLRL +: 2]];

  // ninth bank: one extra tap ahead of the cascade
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dlyBank_q <= '0;
    end else if (clrIn) begin
      dlyBank_q <= '0;
    end else if (enaIn) begin
      dlyBank_q <= scanIn;
    end
  end

  assign scanOut = bankA_q[NMUL-1];

  // ---------------- input banks and multipliers ----------------
  function automatic logic [PRODW-1:0] mulOp(input logic [OPW-1:0] a, input logic [OPW-1:0] b,
                                             input logic sa, input logic sb, input hdm_width_e w);
    logic signed [OPW:0]   ea;
    logic signed [OPW:0]   eb;
    logic signed [2*OPW+1:0] pr;
    case (w)
      W9: begin
        ea = signed'({{10{sa && a[8]}}, a[8:0]});
        eb = signed'({{10{sb && b[8]}}, b[8:0]});
      end
      W12: begin
        ea = signed'({{7{sa && a[11]}}, a[11:0]});
        eb = signed'({{7{sb && b[11]}}, b[11:0]});
      end
      default: begin
        ea = signed'({sa && a[OPW-1], a});
        eb = signed'({sb && b[OPW-1], b});
      end
    endcase
    pr = ea * eb;
    return pr[PRODW-1:0];
  endfunction

  for (genvar i = 0; i < NMUL; i++) begin : g_mul
    localparam int AI = i % 2;
    localparam int BI = i / 2;
    logic [OPW-1:0] aSrc;
    logic [OPW-1:0] bSrc;
    logic [OPW-1:0] aChain;
    logic [OPW-1:0] am;
    logic [OPW-1:0] bm;
    logic           sa;
    logic           sb;
    logic [PRODW-1:0] p;

    if (i == 0) begin : g_head
      assign aChain = ctrl_q[CTRL_DLY] ? dlyBank_q : scanIn;
      // loopback takes the registered upper half; zeroLoopback blanks it
      assign bSrc = lbAct ? (zeroLoopback ? '0 : result_q[0][2*OPW-1:OPW])
                          : dataB[OPW-1:0];
    end else begin : g_tail
      assign aChain = bankA_q[i-1];
      assign bSrc   = dataB[i*OPW +: OPW];
    end
    assign aSrc = cascAct ? aChain : dataA[i*OPW +: OPW];

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        bankA_q[i] <= '0;
        bankB_q[i] <= '0;
      end else if (clrIn) begin
        bankA_q[i] <= '0;
        bankB_q[i] <= '0;
      end else if (enaIn) begin
        bankA_q[i] <= aSrc;
        bankB_q[i] <= bSrc;
      end
    end

    assign aOp[i] = ctrl_q[CTRL_BYP + i] ? aSrc : bankA_q[i];
    assign bOp[i] = ctrl_q[CTRL_BYP + NMUL + i] ? bSrc : bankB_q[i];

    // 36x36: multiplier i forms A[i%2] x B[i/2]; only upper words carry a sign
    assign am = w36 ? aOp[AI] : aOp[i];
    assign bm = w36 ? bOp[BI] : bOp[i];
    assign sa = signA && (!w36 || AI == 1);
    assign sb = signB && (!w36 || BI == 1);
    assign p  = mulOp(am, bm, sa, sb, width);
    assign prod[i] = signed'({{(PW-PRODW){(sa || sb) && p[PRODW-1]}}, p});
  end

  // ---------------- first-stage adders ----------------
  // in 36x36 adder 0 sums the two cross products
  always_comb begin
    logic signed [SW-1:0] x0;
    logic signed [SW-1:0] y0;
    logic signed [SW-1:0] x1;
    logic signed [SW-1:0] y1;
    x0 = SW'(w36 ? prod[1] : prod[0]);
    y0 = SW'(w36 ? prod[2] : prod[1]);
    x1 = SW'(prod[2]);
    y1 = SW'(prod[3]);
    s[0] = (ctrl_q[CTRL_SUB0] && !w36) ? x0 - y0 : x0 + y0;
    s[1] = ctrl_q[CTRL_SUB1] ? x1 - y1 : x1 + y1;
  end

  // ---------------- pipeline stage ----------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pipeS_q[0] <= '0;
      pipeS_q[1] <= '0;
      pipeP0_q   <= '0;
      pipeP3_q   <= '0;
    end else if (clrL) begin
      pipeS_q[0] <= '0;
      pipeS_q[1] <= '0;
      pipeP0_q   <= '0;
      pipeP3_q   <= '0;
    end else if (enaL) begin
      pipeS_q[0] <= s[0];
      pipeS_q[1] <= s[1];
      pipeP0_q   <= prod[0];
      pipeP3_q   <= prod[3];
    end
  end

  assign st2S[0] = ctrl_q[CTRL_PIPE] ? pipeS_q[0] : s[0];
  assign st2S[1] = ctrl_q[CTRL_PIPE] ? pipeS_q[1] : s[1];
  assign st2P0   = ctrl_q[CTRL_PIPE] ? pipeP0_q : prod[0];
  assign st2P3   = ctrl_q[CTRL_PIPE] ? pipeP3_q : prod[3];

  // ---------------- second-stage adders ----------------
  // only this half's products and chainIn (S2_SUM4 with CTRL_CHAIN set) reach here
  assign sum4   = {{(ACCW-SW){st2S[0][SW-1]}}, st2S[0]} + {{(ACCW-SW){st2S[1][SW-1]}}, st2S[1]};
  assign m72    = {st2P3[PRODW-1:0], st2P0[PRODW-1:0]} + {{(72-SW-OPW){st2S[0][SW-1]}}, st2S[0], {OPW{1'b0}}};
  assign accSum = {acc_q[ACCW-1], acc_q} + {sum4[ACCW-1], sum4};

  always_comb begin
    st2[0] = {{(ACCW-SW){st2S[0][SW-1]}}, st2S[0]};
    st2[1] = {{(ACCW-SW){st2S[1][SW-1]}}, st2S[1]};
    case (s2Mode)
      S2_PASS: begin
      end
      S2_SUM4: begin
        st2[0] = ctrl_q[CTRL_CHAIN] ? sum4 + chainIn : sum4;
      end
      S2_ACCUM: begin
        st2[0] = accSum[ACCW-1:0];
      end
      S2_MUL36: begin
        st2[0] = m72[ACCW-1:0];
        st2[1] = {{(2*ACCW-72){m72[71]}}, m72[71:ACCW]};
      end
      default: begin
      end
    endcase
  end

  // accumulator feedback always goes through acc_q, so no loop can form
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q    <= '0;
      accOvf_q <= 1'b0;
    end else if (clrL) begin
      acc_q    <= '0;
      accOvf_q <= 1'b0;
    end else if (enaL && s2Mode == S2_ACCUM) begin
      acc_q    <= accSum[ACCW-1:0];
      accOvf_q <= accSum[ACCW] != accSum[ACCW-1];
    end
  end

  // ---------------- round and saturate, result registers ----------------
  for (genvar u = 0; u < 2; u++) begin : g_rs
    hdm_rs_if rsIf ();
    hdm_round_sat u_rs (
      .rs (rsIf.unit)
    );
    always_comb begin
      case (rsSrc)
        RS_MULT: rsIf.din = {{(ACCW-PW){prod[2*u][PW-1]}}, prod[2*u]};
        RS_ADD1: rsIf.din = {{(ACCW-SW){s[u][SW-1]}}, s[u]};
        RS_PIPE: rsIf.din = {{(ACCW-SW){pipeS_q[u][SW-1]}}, pipeS_q[u]};
        RS_ADD2: rsIf.din = st2[u];
        default: rsIf.din = st2[u];
      endcase
    end
    assign rsIf.doRound = roundEn;
    assign rsIf.doSat   = saturateEn;
    assign rsIf.rndPos  = arith_q[ARITH_RND +: POSW];
    assign rsIf.satMsb  = arith_q[ARITH_SAT +: POSW];

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        result_q[u] <= '0;
        satOvf_q[u] <= 1'b0;
      end else if (clrL) begin
        result_q[u] <= '0;
        satOvf_q[u] <= 1'b0;
      end else if (enaL) begin
        result_q[u] <= rsIf.dout;
        satOvf_q[u] <= rsIf.ovf;
      end
    end
  end

  assign result0 = result_q[0];
  assign result1 = result_q[1];
  assign satOvf  = satOvf_q;
  assign accOvf  = accOvf_q;

  // ---------------- checks ----------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_bank_hold:    assert property (!enaIn && !clrIn |=> $stable(bankA_q[2]) && $stable(bankB_q[2]))
    else $error("input bank moved while enable low");
  a_bank_clear:   assert property (clrIn |=> bankA_q[0] == '0 && bankB_q[3] == '0)
    else $error("input bank not cleared");
  a_cascade_tap:  assert property (cascAct && enaIn && !clrIn ##1 cascAct && enaIn && !clrIn
                                   |=> bankA_q[2] == $past(bankA_q[0], 2))
    else $error("cascade tap did not shift");
  a_parallel_in:  assert property (!cascAct && enaIn && !clrIn |=> bankA_q[1] == $past(dataA[2*OPW-1:OPW]))
    else $error("parallel operand not captured");
  a_loop_feed:    assert property (lbAct && !zeroLoopback && enaIn && !clrIn
                                   |=> bankB_q[0] == $past(result_q[0][2*OPW-1:OPW]))
    else $error("loopback operand wrong");
  a_loop_width:   assert property (ctrl_q[CTRL_LOOP] && width != W18 && enaIn && !clrIn
                                   |=> bankB_q[0] == $past(dataB[OPW-1:0]))
    else $error("loopback active outside 18x18");
  a_unsigned_prod: assert property (!signA && !signB |-> !prod[0][PW-1] && !prod[3][PW-1])
    else $error("unsigned product went negative");
  a_pipe_delay:   assert property (ctrl_q[CTRL_PIPE] && enaL && !clrL ##1 $stable(ctrl_q)
                                   |-> st2S[1] == $past(s[1]))
    else $error("pipeline stage latency wrong");
  a_acc_step:     assert property (s2Mode == S2_ACCUM && enaL && !clrL
                                   |=> acc_q == $past(acc_q) + $past(sum4))
    else $error("accumulator step wrong");

  c_cascade: cover property (cascAct && enaIn ##1 enaIn ##1 enaIn);
  c_loopback: cover property (lbAct && !zeroLoopback && enaIn);
  c_accum_ovf: cover property (s2Mode == S2_ACCUM ##1 accOvf_q);
  c_sat: cover property (saturateEn && roundEn ##1 satOvf_q[0]);
endmodule // hdm_half_mac

// ### tb/hdm_fabric_model.sv
// Purpose: fabric side that presents operands and sign controls to one half slice
// Assumes: bench raises put for one cycle per sample, except the accumulate test, which holds it for a steady sample
// Notes: idle operand lines toggle every cycle so stale data never looks valid
`timescale 1ns/1ps
module hdm_fabric_model
  import hdm_pkg::*;
(
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic                put,
  input  wire logic [NMUL*OPW-1:0] opA,
  input  wire logic [NMUL*OPW-1:0] opB,
  input  wire logic                sa,
  input  wire logic                sb,
  output logic      [NMUL*OPW-1:0] dataA,
  output logic      [NMUL*OPW-1:0] dataB,
  output logic                     signA,
  output logic                     signB
);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dataA <= '0;
      dataB <= '0;
    end else if (put) begin
      dataA <= opA;
      dataB <= opB;
    end else begin
      dataA <= ~dataA;
      dataB <= ~dataB;
    end
  end
  // one sign per operand leg for the whole half, held between samples
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      signA <= 1'b0;
      signB <= 1'b0;
    end else if (put) begin
      signA <= sa;
      signB <= sb;
    end
  end
endmodule // hdm_fabric_model

// ### tb/hdm_half_mac_tb.sv
// Purpose: self-checking bench for the half multiply-add path
// Assumes: zero-wait APB slave; rounding checked only on a value that is not a tie
// Notes: idle operands toggle, so each check sits in the one cycle its result stands, bar the checks made while enable line 1 holds the banks
`timescale 1ns/1ps
module hdm_half_mac_tb;
  import hdm_pkg::*;
  logic                mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, accOvf;
  logic                put = 0, sa = 0, sb = 0, signA, signB, saturateEn = 0, roundEn = 0;
  logic [11:0]         paddr = '0;
  logic [31:0]         pwdata = '0, prdata, rq;
  logic [3:0]          ena = 4'hf, aclr = 4'h0;
  logic [NMUL*OPW-1:0] opA = '0, opB = '0, dataA, dataB;
  logic [OPW-1:0]      scanOut, scanIn = '0;
  logic [ACCW-1:0]     result0, result1, e0, e1;
  logic [1:0]          satOvf;
  logic                re;
  int                  bad_count = 0, checks = 0;
  localparam logic [71:0] VA = 72'h80_0048_d1ff_ff2a_bcd ^ 72'h0;
  localparam logic [71:0] VB = 72'hc0_0000_1ebf_fc04_101;

  always #2.5 mclk = ~mclk;

  hdm_fabric_model hdm_fabric_model_inst (.mclk(mclk), .rst_n(rst_n), .put(put), .opA(opA), .opB(opB), .sa(sa),
    .sb(sb), .dataA(dataA), .dataB(dataB), .signA(signA), .signB(signB));
  hdm_half_mac hdm_half_mac_inst (.mclk(mclk), .rst_n(rst_n), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .ena(ena), .aclr(aclr), .dataA(dataA), .dataB(dataB), .signA(signA), .signB(signB), .roundEn(roundEn),
    .saturateEn(saturateEn), .zeroLoopback(1'b0), .scanIn(scanIn), .scanOut(scanOut), .chainIn(44'h0),
    .result0(result0), .result1(result1), .satOvf(satOvf), .accOvf(accOvf));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [87:0] seen, input logic [87:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // the request stays put until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin @(posedge mclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin bad_count++; report_and_stop(); end
    rq = prdata;
    re = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
    apb(1'b0, a, 32'h0);
    chk(rq, exp);
    chk(re, err);
  endtask

  function automatic logic [43:0] ext(input logic [17:0] v, input logic s, input int n);
    logic [43:0] m;
    m = (44'h1 << n) - 44'h1;
    ext = {26'h0, v} & m;
    if (s && v[n-1]) ext = ext | ~m;
  endfunction

  function automatic logic [43:0] pr(input int i, input int n);
    pr = ext(opA[i*18 +: 18], sa, n) * ext(opB[i*18 +: 18], sb, n);
  endfunction

  function automatic logic [31:0] cfg(input int w, input int s2, input int rs, input int pipe, input int sub,
                                      input int byp);
    cfg = 32'(w) << CTRL_WID | 32'(s2) << CTRL_S2 | 32'(rs) << CTRL_RSRC | 32'(pipe) << CTRL_PIPE
        | 32'(sub) << CTRL_SUB0 | 32'(sub) << CTRL_SUB1 | 32'(byp) << CTRL_BYP;
  endfunction

  // configure, hand one sample to the fabric model, wait the expected latency
  task automatic run(input logic [31:0] c, input logic [71:0] a, input logic [71:0] b, input logic s_a,
                     input logic s_b, input int lat);
    apb(1'b1, ADDR_CTRL, c);
    @(posedge mclk);
    put <= 1'b1; opA <= a; opB <= b; sa <= s_a; sb <= s_b;
    @(posedge mclk);
    put <= 1'b0;
    repeat (lat) @(posedge mclk);
    #1;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    #1;
    chk({result1, result0}, 88'h0);
    chk(scanOut, 18'h0);
    rdchk(ADDR_CTRL, CTRL_RST, 1'b0);
    rdchk(ADDR_ARITH, ARITH_RST, 1'b0);
    rdchk(ADDR_STAT, 32'h0, 1'b0);
    rdchk(12'h00c, 32'h0, 1'b1);
    apb(1'b1, ADDR_ARITH, 32'h0000_0a05);
    rdchk(ADDR_ARITH, 32'h0000_0a05, 1'b0);
    apb(1'b1, ADDR_STAT, 32'hffff_ffff);
    rdchk(ADDR_STAT, 32'h0, 1'b0);
    apb(1'b1, ADDR_ARITH, 32'h0);
    // every sign pairing, add and subtract, operands straight to the multipliers
    for (int k = 0; k < 8; k++) begin
      run(cfg(W18, S2_PASS, RS_ADD1, 0, k / 4, 8'hff), VA, VB, k[0], k[1], 1);
      e0 = (k / 4) ? pr(0, 18) - pr(1, 18) : pr(0, 18) + pr(1, 18);
      e1 = (k / 4) ? pr(2, 18) - pr(3, 18) : pr(2, 18) + pr(3, 18);
      chk(result0, e0);
      chk(result1, e1);
    end
    for (int w = 0; w < 2; w++) begin
      run(cfg(w, S2_PASS, RS_ADD1, 0, 0, 8'hff), VA, VB, 1'b1, 1'b0, 1);
      e0 = pr(0, 9 + 3 * w) + pr(1, 9 + 3 * w);
      chk(result0, e0);
    end
    run(cfg(W18, S2_PASS, RS_ADD1, 0, 0, 0), VA, VB, 1'b1, 1'b1, 2);
    e0 = pr(0, 18) + pr(1, 18);
    chk(result0, e0);
    // the pipeline sits in the path only when the unit reads the second stage or RS_PIPE
    run(cfg(W18, S2_PASS, RS_ADD2, 1, 0, 8'hff), VA, VB, 1'b0, 1'b1, 2);
    e1 = pr(2, 18) + pr(3, 18);
    chk(result1, e1);
    // input banks on enable line 1, later stages cleared by line 1
    run(cfg(W18, S2_PASS, RS_ADD1, 0, 0, 0) | 32'h1 << CTRL_ENAI | 32'h1 << CTRL_CLRL, VA, VB, 1'b1, 1'b0, 0);
    e0 = pr(0, 18) + pr(1, 18);
    // drop line 1 just after the banks took the sample
    @(posedge mclk);
    ena <= 4'b1101;
    @(posedge mclk);
    #1;
    chk(result0, e0);
    chk(scanOut, VA[71:54]);
    repeat (3) @(posedge mclk);
    #1;
    chk(result0, e0);
    @(posedge mclk);
    aclr <= 4'b0001;
    ena <= 4'hf;
    repeat (2) @(posedge mclk);
    #1;
    chk(result0, 44'h0);
    chk(scanOut, 18'h0);
    @(posedge mclk);
    aclr <= 4'h0;
    run(cfg(W18, S2_SUM4, RS_ADD2, 0, 0, 8'hff), VA, VB, 1'b1, 1'b1, 1);
    e0 = pr(0, 18) + pr(1, 18) + pr(2, 18) + pr(3, 18);
    chk(result0, e0);
    // round off four lsbs: 9 becomes 16, 0 stays 0
    apb(1'b1, ADDR_ARITH, 32'(4) << ARITH_RND);
    roundEn <= 1'b1;
    run(cfg(W18, S2_PASS, RS_ADD1, 0, 0, 8'hff), 72'h3, 72'h3, 1'b0, 1'b0, 1);
    chk(result0, 44'h10);
    chk(result1, 44'h0);
    // clamp to 2^20 range: large positive then large negative product
    apb(1'b1, ADDR_ARITH, 32'(20) << ARITH_SAT);
    saturateEn <= 1'b1;
    roundEn <= 1'b0;
    run(cfg(W18, S2_PASS, RS_ADD1, 0, 0, 8'hff), 72'h1ffff, 72'h1ffff, 1'b1, 1'b1, 1);
    chk(result0, 44'h000_000f_ffff);
    chk(satOvf, 2'b01);
    rdchk(ADDR_STAT, 32'h1, 1'b0);
    run(cfg(W18, S2_PASS, RS_ADD1, 0, 0, 8'hff), 72'h1ffff, 72'h20000, 1'b1, 1'b1, 1);
    chk(result0, 44'hfff_fff0_0000);
    apb(1'b1, ADDR_ARITH, 32'h0);
    saturateEn <= 1'b0;
    // wide product spans both result words
    run(cfg(W36, S2_MUL36, RS_ADD2, 0, 0, 8'hff), VA, VB, 1'b0, 1'b0, 1);
    chk({result1[27:0], result0}, {36'h0, VA[35:0]} * {36'h0, VB[35:0]});
    // delay bank plus four taps: scanOut shows what scanIn held five edges back
    apb(1'b1, ADDR_CTRL, cfg(W18, S2_PASS, RS_ADD1, 0, 0, 0) | 32'h1 << CTRL_CASC | 32'h1 << CTRL_DLY);
    for (int j = 1; j < 7; j++) begin
      scanIn <= 18'(j);
      @(posedge mclk);
    end
    #1;
    chk(scanOut, 18'h2);
    rdchk(ADDR_STAT, 32'h10, 1'b0);
    apb(1'b1, ADDR_CTRL, cfg(W12, S2_PASS, RS_ADD1, 0, 0, 0) | 32'h3 << CTRL_CASC);
    rdchk(ADDR_STAT, 32'h0, 1'b0);
    apb(1'b1, ADDR_CTRL, cfg(W18, S2_PASS, RS_ADD1, 0, 0, 0) | 32'h1 << CTRL_LOOP);
    rdchk(ADDR_STAT, 32'h8, 1'b0);
    // accumulate a held sample three times from a cleared register
    aclr <= 4'h1;
    apb(1'b1, ADDR_CTRL, cfg(W18, S2_ACCUM, RS_ADD2, 0, 0, 8'hff));
    put <= 1'b1; opA <= VA; opB <= VB; sa <= 1'b1; sb <= 1'b1;
    @(posedge mclk);
    aclr <= 4'h0;
    repeat (3) @(posedge mclk);
    #1;
    e0 = 3 * (pr(0, 18) + pr(1, 18) + pr(2, 18) + pr(3, 18));
    chk(result0, e0);
    chk(accOvf, 1'b0);
    @(posedge mclk);
    put <= 1'b0;
    report_and_stop();
  end
endmodule // hdm_half_mac_tb
